// *** shared/srw_pkg.sv ***
// Constants and carrier types for the supervisory reset and watchdog block
package srw_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned RESET_PULSE_MS = 200;
    localparam int unsigned WD_PERIOD_MS = 1600;
    localparam int unsigned CE_HOLD_US = 15;
    localparam int unsigned RESET_PULSE_CYC = (CLK_HZ / 1000) * RESET_PULSE_MS;
    localparam int unsigned WD_PERIOD_CYC = (CLK_HZ / 1000) * WD_PERIOD_MS;
    localparam int unsigned CE_HOLD_CYC = (CLK_HZ / 1_000_000) * CE_HOLD_US;
    localparam int CNT_W = 32;

    // Comparator indications coming from the analog front end
    typedef struct packed {
        logic supply_low;      // Main supply below reset threshold
        logic main_below_cell; // Main supply below backup cell
        logic sense_low;       // Power-fail sense below trip level
    } srw_cmp_t;

    // Watchdog kick pin as seen by the block
    typedef struct packed {
        logic level;  // Sampled level
        logic floats; // Pin is undriven
    } srw_kick_t;

    typedef enum logic [1:0] {
        SRW_RUN,
        SRW_HOLD,
        SRW_TIMEOUT
    } srw_state_t;
endpackage

// *** rtl/srw_supervisor.sv ***
// Supervisory reset, watchdog, chip-enable gating and supply select
// Functional notes
// RQ1 - Every triggered reset drives the reset output low for 200 ms.
// RQ2 - Reset low while supply low or manual reset low, then 200 ms longer.
// RQ3 - Low manual reset input asserts reset as long as held low.
// RQ4 - Kick input steady beyond watchdog period expires timer and triggers reset.
// RQ5 - Watchdog period is 1.6 s; host toggles kick within it.
// RQ6 - Watchdog timer cleared by reset, floating kick, and every kick edge.
// RQ7 - Floating or undriven kick input disables the watchdog entirely.
// RQ8 - Gated chip-enable low only when input low and reset not asserted.
// RQ9 - Input low at reset entry keeps gated output low 15 us or until high.
// RQ10 - On backup cell the gated chip-enable output is held high.
// RQ11 - Power-fail flag low when sense low or main below cell.
// RQ12 - RAM node fed from main when above threshold or cell, else cell; code feeds from cell whenever main is below cell.
// RQ13 - Supply below threshold clears the reset timer; restarts on recovery.
// RQ14 - All timeouts are counters with terminal counts derived from clock rate.
`timescale 1ns/1ns
module srw_supervisor
    import srw_pkg::*;
#(
    parameter int unsigned RESET_CYC = RESET_PULSE_CYC, // Reset pulse length
    parameter int unsigned WD_CYC = WD_PERIOD_CYC,      // Watchdog period
    parameter int unsigned CE_CYC = CE_HOLD_CYC         // Chip-enable hold
) (
    input wire logic ref_clk_i,          // 50 MHz reference clock
    input wire logic resetn_i,           // Async reset, active low
    input wire srw_cmp_t cmp_i,          // Comparator indications
    input wire srw_kick_t kick_i,        // Watchdog kick pin
    input wire logic manual_reset_n_i,   // Manual reset, active low
    input wire logic ce_n_i,             // Chip-enable from host, active low
    output logic reset_n_o,              // Reset to host, active low
    output logic ce_gated_n_o,           // Gated chip-enable to RAM, active low
    output logic powerfail_flag_n_o,     // Power-fail flag, active low
    output logic ram_on_main_o           // RAM node fed from main supply
);
    srw_state_t state_q;
    logic [CNT_W-1:0] rst_cnt_q;
    logic [CNT_W-1:0] wd_cnt_q;
    logic [CNT_W-1:0] ce_cnt_q;
    logic kick_prev_q;
    logic ce_hold_q;
    logic hold_req;
    logic wd_expire;
    logic in_reset;
    logic on_main_d;

    function automatic logic at_count(input logic [CNT_W-1:0] cnt, input int unsigned lim);
        at_count = (cnt >= CNT_W'(lim - 1));
    endfunction

    assign hold_req = cmp_i.supply_low | ~manual_reset_n_i; // RQ2 RQ3
    assign in_reset = (state_q != SRW_RUN);
    assign on_main_d = ~cmp_i.main_below_cell; // RQ12

    // Reset sequencing
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= SRW_HOLD;
            rst_cnt_q <= '0;
        end else begin
            unique case (state_q)
                SRW_RUN: begin
                    rst_cnt_q <= '0;
                    if (hold_req) begin
                        state_q <= SRW_HOLD;
                    end else if (wd_expire) begin
                        state_q <= SRW_TIMEOUT; // RQ4
                    end
                end
                SRW_HOLD: begin
                    rst_cnt_q <= '0; // RQ13
                    if (!hold_req) begin
                        state_q <= SRW_TIMEOUT;
                    end
                end
                SRW_TIMEOUT: begin
                    if (hold_req) begin
                        state_q <= SRW_HOLD;
                        rst_cnt_q <= '0; // RQ13
                    end else if (at_count(rst_cnt_q, RESET_CYC)) begin
                        state_q <= SRW_RUN; // RQ1 RQ2
                        rst_cnt_q <= '0;
                    end else begin
                        rst_cnt_q <= rst_cnt_q + 1'b1; // RQ14
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reset_n_o <= 1'b0;
        end else begin
            reset_n_o <= (state_q == SRW_RUN) && !hold_req && !wd_expire;
        end
    end

    // Watchdog
    assign wd_expire = !kick_i.floats && at_count(wd_cnt_q, WD_CYC); // RQ5 RQ7

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            kick_prev_q <= 1'b0;
            wd_cnt_q <= '0;
        end else begin
            kick_prev_q <= kick_i.level;
            if (in_reset || kick_i.floats || kick_i.level != kick_prev_q || wd_expire) begin
                wd_cnt_q <= '0; // RQ6 RQ7
            end else begin
                wd_cnt_q <= wd_cnt_q + 1'b1; // RQ4 RQ14
            end
        end
    end

    // Chip-enable gating
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ce_hold_q <= 1'b0;
            ce_cnt_q <= '0;
        end else begin
            if (!in_reset) begin
                ce_hold_q <= 1'b0;
                ce_cnt_q <= '0;
                if (hold_req || wd_expire) begin
                    ce_hold_q <= !ce_n_i; // RQ9
                end
            end else if (ce_hold_q) begin
                if (ce_n_i || at_count(ce_cnt_q, CE_CYC)) begin
                    ce_hold_q <= 1'b0; // RQ9
                end
                ce_cnt_q <= ce_cnt_q + 1'b1; // RQ14
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ce_gated_n_o <= 1'b1;
        end else if (!on_main_d) begin
            ce_gated_n_o <= 1'b1; // RQ10
        end else if (!in_reset && !hold_req && !wd_expire) begin
            ce_gated_n_o <= ce_n_i; // RQ8
        end else begin
            ce_gated_n_o <= ce_n_i | ~(ce_hold_q | ~in_reset); // RQ9
        end
    end

    // Power-fail flag and supply select
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            powerfail_flag_n_o <= 1'b1;
            ram_on_main_o <= 1'b1;
        end else begin
            powerfail_flag_n_o <= !(cmp_i.sense_low || cmp_i.main_below_cell); // RQ11
            ram_on_main_o <= on_main_d; // RQ12
        end
    end

    // Checks
    sequence hold_then_release;
        hold_req ##1 !hold_req;
    endsequence

    reset_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ2
        hold_req |=> !reset_n_o) else $error("reset high while hold requested");
    manual_low_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ3
        !manual_reset_n_i |=> !reset_n_o) else $error("manual reset ignored");
    // Kick edge seen while the pin is driven
    sequence kick_edge;
        !kick_i.floats && kick_i.level != kick_prev_q;
    endsequence

    pulse_start_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ13
        hold_then_release |=> state_q == SRW_TIMEOUT && rst_cnt_q == '0)
        else $error("reset timer not restarted");
    pulse_len_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ1
        $rose(reset_n_o) |-> $past(rst_cnt_q, 2) == CNT_W'(RESET_CYC - 1))
        else $error("reset pulse length wrong");
    pulse_count_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ1
        rst_cnt_q < CNT_W'(RESET_CYC))
        else $error("reset timer overran");
    reset_entry_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ4
        wd_expire && !in_reset |=> !reset_n_o)
        else $error("watchdog expiry did not drop reset");
    wd_count_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ5
        wd_cnt_q < CNT_W'(WD_CYC))
        else $error("watchdog counter overran");
    wd_kick_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ6
        kick_edge |=> wd_cnt_q == '0)
        else $error("kick edge did not clear watchdog");
    wd_fire_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ4
        wd_expire && !in_reset && !hold_req |=> state_q == SRW_TIMEOUT)
        else $error("watchdog expiry lost");
    wd_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ6
        (in_reset || kick_i.floats) |=> wd_cnt_q == '0) else $error("watchdog not cleared");
    wd_float_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ7
        kick_i.floats |-> !wd_expire) else $error("floating kick fired watchdog");
    ce_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ8
        !ce_gated_n_o |-> $past(!ce_n_i)) else $error("gated enable low without input");
    ce_blocked_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ8
        in_reset && !ce_hold_q |=> ce_gated_n_o)
        else $error("gated enable passed during reset");
    ce_hold_end_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ9
        ce_hold_q && in_reset && ce_n_i |=> !ce_hold_q)
        else $error("hold kept after input high");
    ce_hold_len_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ9
        ce_hold_q |-> ce_cnt_q < CNT_W'(CE_CYC))
        else $error("chip-enable hold too long");
    ce_backup_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ10
        !ram_on_main_o |-> ce_gated_n_o) else $error("gated enable low on cell");
    pf_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ11
        (cmp_i.sense_low || cmp_i.main_below_cell) |=> !powerfail_flag_n_o)
        else $error("power-fail flag not raised");
    pf_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ11
        !(cmp_i.sense_low || cmp_i.main_below_cell) |=> powerfail_flag_n_o)
        else $error("power-fail flag stuck low");
    ram_select_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RQ12
        ##1 ram_on_main_o == !$past(cmp_i.main_below_cell))
        else $error("RAM supply select wrong");
endmodule

// *** testbench/srw_host_model.sv ***
// Host model that kicks the watchdog or releases its pin
`timescale 1ns/1ns
module srw_host_model
    import srw_pkg::*;
(
    input wire logic clk_i,     // Reference clock
    input wire logic kick_on_i, // Toggle the kick pin
    input wire logic float_i,   // Release the kick pin
    output srw_kick_t kick_o    // Kick pin seen by block
);
    logic [3:0] tick_q = 4'h0;
    initial kick_o = 2'h0;
    always @(posedge clk_i) begin
        tick_q <= tick_q + 4'h1;
        kick_o.floats <= float_i;
        if (float_i && !kick_o.floats) begin
            kick_o.level <= ~kick_o.level; // Released pin drifts
        end else if (kick_on_i && !float_i && tick_q == 4'hF) begin
            kick_o.level <= ~kick_o.level;
        end
    end
endmodule

// *** testbench/srw_supervisor_test.sv ***
// Self-checking bench for the supervisory reset block
`timescale 1ns/1ns
module srw_supervisor_test;
    import srw_pkg::*;
    localparam int RC = 20;
    localparam int WC = 50;
    localparam int CC = 5;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    srw_cmp_t cmp_i = 3'h0;
    logic manual_reset_n_i = 1'b1;
    logic ce_n_i = 1'b1;
    logic kick_on = 1'b0;
    logic kick_off = 1'b0;
    srw_kick_t kick_i;
    logic reset_n_o;
    logic ce_gated_n_o;
    logic powerfail_flag_n_o;
    logic ram_on_main_o;
    wire [3:0] outs = {ram_on_main_o, powerfail_flag_n_o, ce_gated_n_o, reset_n_o};
    int mismatches = 0;
    int comparisons = 0;
    int n;
    always #10 ref_clk_i = ~ref_clk_i;
    srw_supervisor #(.RESET_CYC(RC), .WD_CYC(WC), .CE_CYC(CC)) srw_supervisor_i (
        .ref_clk_i, .resetn_i, .cmp_i, .kick_i, .manual_reset_n_i, .ce_n_i,
        .reset_n_o, .ce_gated_n_o, .powerfail_flag_n_o, .ram_on_main_o);
    srw_host_model srw_host_model_i (.clk_i(ref_clk_i), .kick_on_i(kick_on),
        .float_i(kick_off), .kick_o(kick_i));
    task automatic chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    // Falling edges until output w shows lvl, at most lim + 1
    task automatic wt(input int w, input logic lvl, input int lim);
        n = 0;
        @(negedge ref_clk_i);
        while (outs[w] !== lvl && n < lim) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk(outs[w], lvl);
    endtask
    task automatic clk(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask
    task automatic t_hold(input int src);
        clk(1);
        if (src == 0) manual_reset_n_i <= 1'b0;
        else cmp_i.supply_low <= 1'b1;
        wt(0, 1'b0, 3);
        clk(30);
        wt(0, 1'b0, 0);
        clk(1);
        manual_reset_n_i <= 1'b1;
        cmp_i.supply_low <= 1'b0;
        wt(0, 1'b1, RC + 5);
        chk(n >= RC - 1, 1'b1);
    endtask
    task automatic t_dog();
        clk(1);
        kick_on <= 1'b1;
        clk(4 * WC);
        wt(0, 1'b1, 0);
        clk(1);
        kick_on <= 1'b0;
        wt(0, 1'b0, WC + 5);
        chk(n >= WC - 18, 1'b1);
        wt(0, 1'b1, RC + 5);
        clk(1);
        kick_off <= 1'b1;
        clk(3 * WC);
        wt(0, 1'b1, 0);
        clk(1);
        kick_off <= 1'b0;
        kick_on <= 1'b1;
    endtask
    task automatic t_ce();
        clk(1);
        ce_n_i <= 1'b0;
        wt(1, 1'b0, 3);
        clk(1);
        manual_reset_n_i <= 1'b0;
        wt(1, 1'b1, CC + 5);
        chk(n >= CC - 1, 1'b1);
        clk(1);
        manual_reset_n_i <= 1'b1;
        wt(0, 1'b1, RC + 5);
        wt(1, 1'b0, 3);
        clk(1);
        manual_reset_n_i <= 1'b0;
        clk(2);
        ce_n_i <= 1'b1;
        wt(1, 1'b1, 2);
        clk(1);
        manual_reset_n_i <= 1'b1;
        wt(0, 1'b1, RC + 5);
    endtask
    task automatic t_pwr();
        clk(1);
        cmp_i.sense_low <= 1'b1;
        wt(2, 1'b0, 3);
        wt(3, 1'b1, 0);
        clk(1);
        cmp_i <= 3'h2;
        ce_n_i <= 1'b0;
        wt(3, 1'b0, 3);
        wt(2, 1'b0, 0);
        wt(1, 1'b1, 0);
        clk(1);
        cmp_i <= 3'h0;
        wt(3, 1'b1, 3);
        wt(2, 1'b1, 0);
        wt(1, 1'b0, 3);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk(2);
        resetn_i <= 1'b1;
        wt(0, 1'b1, RC + 5);
        chk(n >= RC - 1, 1'b1);
        t_hold(0);
        t_hold(1);
        t_dog();
        t_ce();
        t_pwr();
        give_verdict();
    end
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule
